/* rtl/chs_defines.svh */
// offsets, field positions, reset values and timing counts of the charger sequencer
// assumes CLK at 125 MHz and a host on the two-wire serial bus
`ifndef CHS_DEFINES_SVH
`define CHS_DEFINES_SVH
`define CHS_CLK_MHZ      125
`define CHS_T_VALID_MS   30
`define CHS_VALID_CYC    (`CHS_T_VALID_MS * `CHS_CLK_MHZ * 1000)
`define CHS_T_WDOG_S     32
`define CHS_WDOG_CYC     (64'(`CHS_T_WDOG_S) * 64'd1000000 * 64'(`CHS_CLK_MHZ))
`define CHS_T_UNATT_MIN  15
`define CHS_UNATT_CYC    (64'(`CHS_T_UNATT_MIN) * 64'd60000000 * 64'(`CHS_CLK_MHZ))
`define CHS_T_STAT_US    128
`define CHS_STAT_CYC     (`CHS_T_STAT_US * `CHS_CLK_MHZ)
`define CHS_RAMP_CYC     10'h3E8
`define CHS_I2C_ADDR     7'h55
`define CHS_REG_CTRL     8'h00
`define CHS_REG_LIM      8'h01
`define CHS_REG_VOREG    8'h02
`define CHS_REG_ICHG     8'h04
`define CHS_REG_HOLD     8'h05
`define CHS_REG_CEIL     8'h06
`define CHS_B_WDRST      7
`define CHS_B_CE         2
`define CHS_B_HFLAG      4
`define CHS_F_ILIM       7:6
`define CHS_F_VOREG      7:2
`define CHS_F_ICHG       6:4
`define CHS_F_HSEL       2:0
`define CHS_F_CI         6:4
`define CHS_F_CV         3:0
`define CHS_RST_ILIM     2'h0
`define CHS_RST_VOREG    6'h02
`define CHS_RST_ICHG     3'h0
`define CHS_RST_HSEL     3'h0
`define CHS_RST_CEIL     8'h00
`define CHS_VCEIL_BASE   6'h23
`define CHS_VCEIL_TOP    6'h2F
`define CHS_VCEIL_SAT    4'hC
`define CHS_FLT_OVP      3'h1
`define CHS_FLT_TSHUT    3'h5
`define CHS_FLT_TMR      3'h6
`endif

/* rtl/chs_pkg.sv */
// types shared by the charger sequencer and its serial slave
// assumes nothing beyond the constants header
package chs_pkg;
   typedef enum logic [1:0] {ST_NOPWR, ST_VALID, ST_CHARGE, ST_STOP} chs_st_t;
   typedef enum logic [2:0] {IS_IDLE, IS_ADDR, IS_RX, IS_ACK, IS_TX, IS_MACK} chs_ist_t;
   typedef struct packed {
      logic supply_min;
      logic supply_ovp;
      logic host_mode;
      logic vbat_short;
      logic foldback;
      logic tshut;
      logic holdup;
      logic recharge;
   } chs_pins_t;
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } chs_wr_t;
   typedef struct packed {
      logic       load;
      logic       chg;
      logic [1:0] ilim;
      logic       fold;
      logic [2:0] icode;
      logic [5:0] vcode;
      logic [2:0] hsel;
      logic       stat;
   } chs_ctl_t;
endpackage

/* rtl/chs_i2c.sv */
// two-wire serial slave: pointer byte, then auto-incrementing data bytes
// assumes raw scl and sda pins; rdata answers raddr in the same cycle
`timescale 1ns/1ps
`include "chs_defines.svh"
module chs_i2c (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             scl,
   input  wire logic             sda_i,
   output logic                  sda_oe,
   output chs_pkg::chs_wr_t      wr,
   output logic [7:0]            raddr,
   input  wire logic [7:0]       rdata
);
   import chs_pkg::*;
   typedef struct packed {
      logic [1:0] c1;
      logic [1:0] c2;
      logic [1:0] c3;
      chs_ist_t   st;
      logic [3:0] bc;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic       first;
      logic       rw;
      logic       nack;
      logic       oe;
      chs_wr_t    wr;
   } chs_i2c_t;
   chs_i2c_t s;
   chs_i2c_t n;
   logic     rise;
   logic     fall;
   logic     start;
   logic     stop;
   // edges only from the second stage and its delayed copy
   assign rise  = s.c2[1] & ~s.c3[1];
   assign fall  = ~s.c2[1] & s.c3[1];
   assign start = s.c2[1] & s.c3[1] & ~s.c2[0] & s.c3[0];
   assign stop  = s.c2[1] & s.c3[1] & s.c2[0] & ~s.c3[0];
   always_comb begin
      n = s;
      n.c1 = {scl, sda_i};
      n.c2 = s.c1;
      n.c3 = s.c2;
      n.wr.wr = 1'h0;
      if (start) begin
         n.st = IS_ADDR;
         n.bc = 4'h0;
         n.first = 1'h1;
         n.oe = 1'h0;
      end else if (stop) begin
         n.st = IS_IDLE;
         n.oe = 1'h0;
      end else begin
         case (s.st)
            IS_ADDR, IS_RX: begin
               if (rise) begin
                  n.sh = {s.sh[6:0], s.c2[0]};
                  n.bc = s.bc + 4'h1;
               end else if (fall && s.bc == 4'h8) begin
                  n.bc = 4'h0;
                  if (s.st == IS_ADDR) begin
                     if (s.sh[7:1] == `CHS_I2C_ADDR) begin
                        n.st = IS_ACK;
                        n.oe = 1'h1;
                        n.rw = s.sh[0];
                     end else begin
                        n.st = IS_IDLE;
                     end
                  end else begin
                     n.st = IS_ACK;
                     n.oe = 1'h1;
                     n.first = 1'h0;
                     if (s.first) begin
                        n.ptr = s.sh;
                     end else begin
                        n.wr = '{wr: 1'h1, addr: s.ptr, data: s.sh};
                        n.ptr = s.ptr + 8'h1;
                     end
                  end
               end
            end
            IS_ACK, IS_MACK: begin
               if (rise && s.st == IS_MACK) begin
                  n.nack = s.c2[0];
               end else if (fall) begin
                  if (s.st == IS_MACK && s.nack) begin
                     n.st = IS_IDLE;
                  end else if (s.rw) begin
                     n.sh = rdata;
                     n.oe = ~rdata[7];
                     n.ptr = s.ptr + 8'h1;
                     n.st = IS_TX;
                  end else begin
                     n.oe = 1'h0;
                     n.st = IS_RX;
                  end
               end
            end
            IS_TX: begin
               if (fall) begin
                  if (s.bc == 4'h7) begin
                     n.oe = 1'h0;
                     n.bc = 4'h0;
                     n.st = IS_MACK;
                  end else begin
                     n.sh = {s.sh[6:0], 1'h0};
                     n.oe = ~s.sh[6];
                     n.bc = s.bc + 4'h1;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
         s.c1 <= 2'h3;
         s.c2 <= 2'h3;
         s.c3 <= 2'h3;
      end else begin
         s <= n;
      end
   end
   assign sda_oe = s.oe;
   assign wr     = s.wr;
   assign raddr  = s.ptr;
endmodule

/* rtl/chs_top.sv */
// charger safety sequencer: supply validation, host timers, limits and ceiling
// assumes analog comparators on PINS and a host on the two-wire bus
`timescale 1ns/1ps
`include "chs_defines.svh"
module chs_top #(
   parameter logic [21:0] P_VALID_CYC = 22'(`CHS_VALID_CYC),
   parameter logic [31:0] P_WDOG_CYC  = 32'(`CHS_WDOG_CYC),
   parameter logic [36:0] P_UNATT_CYC = 37'(`CHS_UNATT_CYC),
   parameter logic [13:0] P_STAT_CYC  = 14'(`CHS_STAT_CYC)
) (
   input  wire logic               CLK,
   input  wire logic               RESET,
   input  wire chs_pkg::chs_pins_t PINS,
   input  wire logic               SCL,
   input  wire logic               SDA_I,
   output logic                    SDA_O,
   output logic                    SDA_OE,
   output chs_pkg::chs_ctl_t       CTL
);
   import chs_pkg::*;
   typedef struct packed {
      chs_pins_t   p1;
      chs_pins_t   p2;
      chs_pins_t   pp;
      chs_st_t     st;
      logic [21:0] vcnt;
      logic [31:0] wcnt;
      logic [36:0] ucnt;
      logic        wrun;
      logic        urun;
      logic        anywr;
      logic        lock;
      logic        cetmr;
      logic [1:0]  input_current_limit_sel;
      logic        ce;
      logic [5:0]  fvc;
      logic [2:0]  icc;
      logic [2:0]  hsel;
      logic [2:0]  fault;
      logic [7:0]  ceil;
      logic [13:0] scnt;
      logic [9:0]  rcnt;
      chs_ctl_t    ctl;
   } chs_main_t;
   chs_main_t  s;
   chs_main_t  n;
   chs_pins_t  pin;
   chs_pins_t  prv;
   chs_wr_t    w;
   logic [7:0] raddr;
   logic [7:0] rdat;
   logic [2:0] tgt;

   function automatic logic [5:0] vtop(input logic [3:0] c);
      vtop = (c >= `CHS_VCEIL_SAT) ? `CHS_VCEIL_TOP : 6'(`CHS_VCEIL_BASE + 6'(c));
   endfunction
   function automatic logic [5:0] vlim(input logic [5:0] v, input logic [3:0] c);
      vlim = (v > vtop(c)) ? vtop(c) : v;
   endfunction
   function automatic logic [2:0] ilim(input logic [2:0] v, input logic [2:0] c);
      ilim = (v > c) ? c : v;
   endfunction

   chs_i2c u_i2c (
      .clk    (CLK),
      .reset  (RESET),
      .scl    (SCL),
      .sda_i  (SDA_I),
      .sda_oe (SDA_OE),
      .wr     (w),
      .raddr  (raddr),
      .rdata  (rdat)
   );

   // pins are only read after both sync stages
   assign pin = s.p2;
   assign prv = s.pp;
   // foldback forces the lowest current code, which is the reduced level
   assign tgt = pin.foldback ? 3'h0 : ilim(s.icc, s.ceil[`CHS_F_CI]);

   always_comb begin
      n = s;
      n.p1 = PINS;
      n.p2 = s.p1;
      n.pp = s.p2;
      if (s.scnt != 14'h0) begin
         n.scnt = s.scnt - 14'h1;
      end
      if (!pin.tshut) begin
         case (s.st)
            ST_NOPWR: begin
               if (pin.supply_min) begin
                  n.st = ST_VALID;
                  n.vcnt = 22'h0;
                  if (s.cetmr) begin // supply reset frees a timer-set disable
                     n.ce = 1'h0;
                     n.cetmr = 1'h0;
                  end
               end
            end
            ST_VALID: begin
               if (!pin.supply_min) begin
                  n.st = ST_NOPWR;
               end else if (pin.supply_ovp) begin
                  n.vcnt = 22'h0;
               end else if (s.vcnt == P_VALID_CYC - 22'h1) begin
                  n.vcnt = 22'h0;
                  n.st = ST_CHARGE;
                  if (!s.wrun) begin
                     n.urun = 1'h1;
                     n.ucnt = 37'h0;
                  end
               end else begin
                  n.vcnt = s.vcnt + 22'h1;
               end
            end
            ST_CHARGE: begin
               if (!pin.supply_min) begin
                  n.st = ST_NOPWR;
               end else if (pin.supply_ovp) begin
                  n.st = ST_VALID;
                  n.vcnt = 22'h0;
                  n.fault = `CHS_FLT_OVP;
                  n.scnt = P_STAT_CYC;
               end else if (pin.recharge && !prv.recharge) begin
                  n.st = ST_VALID;
                  n.vcnt = 22'h0;
               end else if (s.ce) begin
                  n.st = ST_STOP;
               end
            end
            default: begin
               if (!pin.supply_min) begin
                  n.st = ST_NOPWR;
               end else if (!s.ce) begin
                  n.st = ST_VALID;
                  n.vcnt = 22'h0;
               end
            end
         endcase
         // watchdog keeps running while charging is disabled
         if (s.wrun) begin
            if (s.wcnt == P_WDOG_CYC - 32'h1) begin
               n.wrun = 1'h0;
               n.input_current_limit_sel = `CHS_RST_ILIM;
               n.ce = 1'h0;
               n.cetmr = 1'h0;
               n.fvc = `CHS_RST_VOREG;
               n.icc = `CHS_RST_ICHG;
               n.hsel = `CHS_RST_HSEL;
               n.fault = `CHS_FLT_TMR;
               n.scnt = P_STAT_CYC;
               n.urun = 1'h1;
               n.ucnt = 37'h0;
               if (s.st == ST_CHARGE) begin
                  n.st = ST_VALID;
                  n.vcnt = 22'h0;
               end
            end else begin
               n.wcnt = s.wcnt + 32'h1;
            end
         end
         if (s.urun && s.st == ST_CHARGE) begin
            if (s.ucnt == P_UNATT_CYC - 37'h1) begin
               n.urun = 1'h0;
               n.ce = 1'h1;
               n.cetmr = 1'h1;
               n.fault = `CHS_FLT_TMR;
               n.scnt = P_STAT_CYC;
               n.st = ST_STOP;
            end else begin
               n.ucnt = s.ucnt + 37'h1;
            end
         end
         if (pin.vbat_short && !prv.vbat_short) begin
            n.ceil = `CHS_RST_CEIL;
         end
         if (!pin.vbat_short) begin
            n.lock = 1'h0;
         end
         // writes come last so a write wins over timer events in the same cycle
         if (w.wr) begin
            n.anywr = 1'h1;
            if (w.addr != `CHS_REG_CEIL) begin
               n.lock = 1'h1;
            end
            n.urun = 1'h0;
            n.ucnt = 37'h0;
            if (!n.wrun) begin
               n.wrun = 1'h1;
               n.wcnt = 32'h0;
            end
            if (s.cetmr) begin
               n.ce = 1'h0;
               n.cetmr = 1'h0;
            end
            if (w.addr == `CHS_REG_CTRL) begin
               if (w.data[`CHS_B_WDRST]) begin
                  n.wcnt = 32'h0;
               end
            end else if (w.addr == `CHS_REG_LIM) begin
               n.input_current_limit_sel = w.data[`CHS_F_ILIM];
               n.ce = w.data[`CHS_B_CE];
            end else if (w.addr == `CHS_REG_VOREG) begin
               n.fvc = vlim(w.data[`CHS_F_VOREG], s.ceil[`CHS_F_CV]);
            end else if (w.addr == `CHS_REG_ICHG) begin
               n.icc = ilim(w.data[`CHS_F_ICHG], s.ceil[`CHS_F_CI]);
            end else if (w.addr == `CHS_REG_HOLD) begin
               n.hsel = w.data[`CHS_F_HSEL];
            end else if (w.addr == `CHS_REG_CEIL && !s.lock) begin
               n.ceil = w.data;
            end
         end
         // slow ramp; holds while the hold-up loop pulls the supply down
         if (!(n.st == ST_CHARGE && !n.ce)) begin
            n.ctl.icode = 3'h0;
            n.rcnt = 10'h0;
         end else if (s.ctl.icode > tgt) begin
            n.ctl.icode = tgt;
         end else if (s.ctl.icode < tgt && !pin.holdup) begin
            if (s.rcnt == `CHS_RAMP_CYC - 10'h1) begin
               n.ctl.icode = s.ctl.icode + 3'h1;
               n.rcnt = 10'h0;
            end else begin
               n.rcnt = s.rcnt + 10'h1;
            end
         end
      end else if (!prv.tshut) begin
         n.fault = `CHS_FLT_TSHUT;
         n.scnt = P_STAT_CYC;
      end
      // suspend: all above except the sync stages, the status count and the fault code is frozen, only charging is cut
      n.ctl.load = (n.st == ST_VALID);
      n.ctl.chg = (n.st == ST_CHARGE) && !n.ce && !pin.tshut;
      n.ctl.ilim = (!n.anywr || n.urun) ? {1'h0, pin.host_mode} : n.input_current_limit_sel;
      n.ctl.fold = pin.foldback;
      n.ctl.vcode = vlim(n.fvc, n.ceil[`CHS_F_CV]);
      n.ctl.hsel = n.hsel;
      n.ctl.stat = (n.scnt != 14'h0);
   end

   always_comb begin
      rdat = 8'h00;
      if (raddr == `CHS_REG_CTRL) begin
         rdat = {5'h00, s.fault};
      end else if (raddr == `CHS_REG_LIM) begin
         rdat = {s.input_current_limit_sel, 3'h0, s.ce, 2'h0};
      end else if (raddr == `CHS_REG_VOREG) begin
         rdat = {s.fvc, 2'h0};
      end else if (raddr == `CHS_REG_ICHG) begin
         rdat = {1'h0, s.icc, 4'h0};
      end else if (raddr == `CHS_REG_HOLD) begin
         rdat = {3'h0, pin.holdup, 1'h0, s.hsel};
      end else if (raddr == `CHS_REG_CEIL) begin
         rdat = s.ceil;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         s <= '0; // all timers clear on supply reset
         s.input_current_limit_sel <= `CHS_RST_ILIM;
         s.fvc <= `CHS_RST_VOREG;
         s.icc <= `CHS_RST_ICHG;
         s.hsel <= `CHS_RST_HSEL;
         s.ceil <= `CHS_RST_CEIL;
         s.ctl.vcode <= `CHS_RST_VOREG;
      end else begin
         s <= n;
      end
   end

   // open drain: the slave only ever pulls low
   assign SDA_O = 1'h0;
   assign CTL   = s.ctl;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   // two cycles back: the cycle before chg rises already sees tshut low after a cool-down
   a_start_after_load: assert property ($rose(CTL.chg) && !$past(pin.tshut, 2)
      |-> $past(CTL.load)) else $error("charge began without validation");
   a_valid_full_time: assert property (s.st == ST_VALID && n.st == ST_CHARGE
      |-> s.vcnt == P_VALID_CYC - 22'h1) else $error("validation cut short");
   a_ovp_revalidate: assert property (s.st == ST_CHARGE && pin.supply_min && pin.supply_ovp
      && !pin.tshut |=> s.st == ST_VALID && s.vcnt == 22'h0)
      else $error("overvoltage did not revalidate");
   a_unatt_expiry: assert property (s.urun && s.st == ST_CHARGE && !pin.tshut && !w.wr
      && s.ucnt == P_UNATT_CYC - 37'h1 |=> s.ce && s.fault == `CHS_FLT_TMR && !CTL.chg)
      else $error("unattended expiry not handled");
   a_write_swaps_timer: assert property (w.wr && !pin.tshut |=> !s.urun && s.wrun
      && s.ucnt == 37'h0) else $error("write did not swap timers");
   a_wd_restart_zero: assert property (w.wr && w.addr == `CHS_REG_CTRL && !pin.tshut
      && w.data[`CHS_B_WDRST] |=> s.wcnt == 32'h0) else $error("watchdog not restarted");
   a_wd_expiry: assert property (s.wrun && s.wcnt == P_WDOG_CYC - 32'h1 && !pin.tshut
      && !w.wr |=> s.urun && s.fault == `CHS_FLT_TMR && s.fvc == `CHS_RST_VOREG && CTL.stat)
      else $error("watchdog expiry not handled");
   a_pin_limit: assert property (s.urun |-> CTL.ilim == {1'h0, $past(pin.host_mode)})
      else $error("input limit not from host-mode pin");
   a_ceiling_clamp: assert property (CTL.vcode <= vtop(s.ceil[`CHS_F_CV]))
      else $error("voltage code above ceiling");
   a_ceiling_locked: assert property (s.lock && !(pin.vbat_short && !prv.vbat_short)
      |=> s.ceil == $past(s.ceil)) else $error("locked ceiling changed");
   a_foldback_level: assert property (pin.foldback && !pin.tshut |=> CTL.icode == 3'h0)
      else $error("foldback current not applied");
   a_shutdown_hold: assert property (pin.tshut && prv.tshut |=> $stable(s.wcnt)
      && $stable(s.ucnt) && $stable(s.st) && !CTL.chg)
      else $error("state moved in shutdown");
   a_timer_disable: assert property (s.cetmr && !w.wr && s.st != ST_NOPWR |=> s.ce)
      else $error("timer disable cleared early");

   c_charge_start: cover property ($rose(CTL.chg));
   c_unatt_expire: cover property (s.urun ##1 s.cetmr);
   c_wd_expire: cover property (s.wrun ##1 (!s.wrun && s.urun));
   c_shutdown: cover property ($rose(pin.tshut) ##1 CTL.stat);
endmodule

/* sim/chs_host_model.sv */
// host model: two-wire bus master for the sequencer's serial port
// assumes a pull-up resolves sda outside; scl stands high between frames
`timescale 1ns/1ps
`include "chs_defines.svh"
module chs_host_model (
   output logic      scl,
   output logic      sda_dn,
   input  wire logic sda
);
   logic ack_ok;
   initial begin
      scl = 1'b1;
      sda_dn = 1'b0;
      ack_ok = 1'b1;
   end
   // 64 ns per bit; sda moves only while scl is low
   // changes land on clock edges, so nonblocking keeps the sync stages race free
   task automatic bits9(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         scl <= 1'b0;
         #16 sda_dn <= ~d[i];
         #16 scl <= 1'b1;
         #16 q[i] = sda;
         #16;
      end
   endtask
   // also serves as repeated start
   task automatic start;
      scl <= 1'b0;
      #16 sda_dn <= 1'b0;
      #16 scl <= 1'b1;
      #16 sda_dn <= 1'b1;
      #16;
   endtask
   task automatic stop;
      scl <= 1'b0;
      #16 sda_dn <= 1'b1;
      #16 scl <= 1'b1;
      #16 sda_dn <= 1'b0;
      #32;
   endtask
   task automatic put(input logic [7:0] b);
      logic [8:0] q;
      bits9({b, 1'b1}, q);
      if (q[0] !== 1'b0) ack_ok = 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start;
      put({`CHS_I2C_ADDR, 1'b0});
      put(a);
      put(d);
      stop;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [8:0] q;
      start;
      put({`CHS_I2C_ADDR, 1'b0});
      put(a);
      start;
      put({`CHS_I2C_ADDR, 1'b1});
      bits9(9'h1FF, q);
      d = q[8:1];
      stop;
   endtask
   // whole value twice; a single write already stores every bit while the ceiling is unlocked
   task automatic wr_ceil(input logic [7:0] d);
      wr(`CHS_REG_CEIL, d);
      wr(`CHS_REG_CEIL, d);
   endtask
   // restart before expiry keeps programmed values
   task automatic keepalive;
      wr(`CHS_REG_CTRL, 8'h80);
   endtask
endmodule

/* sim/chs_top_test.sv */
// bench for the charger sequencer: pins driven here, host model on the bus
// assumes shortened timer parameters; expectations from integer models
`timescale 1ns/1ps
module chs_top_test;
   import chs_pkg::*;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   chs_pins_t  pins = '0;
   chs_ctl_t   ctl;
   logic       scl, sda_dn, sda_o, sda_oe;
   wire        sda = ~(sda_dn | sda_oe);
   logic [7:0] q;
   int         n_fail = 0;
   int         checked = 0;
   always #4 clk = ~clk;
   chs_top #(.P_VALID_CYC(22'd20), .P_WDOG_CYC(32'd2000), .P_UNATT_CYC(37'd3000),
      .P_STAT_CYC(14'd8)) u_chs_top (.CLK(clk), .RESET(reset), .PINS(pins), .SCL(scl),
      .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .CTL(ctl));
   chs_host_model u_chs_host_model (.scl(scl), .sda_dn(sda_dn), .sda(sda));
   // float code ceiling: 35 plus code, saturating at 47
   function automatic int vlim(int w, int c);
      int m = (c >= 12) ? 47 : 35 + c;
      return (w > m) ? m : w;
   endfunction
   task automatic chk(logic [17:0] got, logic [17:0] exp, string m);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   // status pulse is short: poll each cycle, bounded
   task automatic wstat(int n);
      for (int i = 0; i < n && ctl.stat !== 1'b1; i++) @(negedge clk);
      chk(ctl.stat, 18'h1, "stat pulse");
   endtask
   task automatic endt(string s);
      $display("test %s done", s);
   endtask
   task automatic final_report;
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #400000;
      n_fail++;
      final_report;
   end
   initial begin
      void'($urandom(32'h757283B2));
      cyc(8);
      reset <= 1'b0;
      cyc(2);
      chk(ctl, 18'h00020, "reset");
      pins.supply_min <= 1'b1;
      pins.vbat_short <= 1'b1;
      cyc(6);
      chk(ctl.load, 18'h1, "load");
      chk(ctl.chg, 18'h0, "early");
      cyc(30);
      chk(ctl.chg, 18'h1, "start");
      chk(ctl.ilim, 18'h0, "pin lim");
      endt("power");
      u_chs_host_model.wr_ceil(8'h10);
      u_chs_host_model.wr(8'h02, 8'hFC);
      u_chs_host_model.wr(8'h04, 8'h70);
      u_chs_host_model.keepalive;
      cyc(1100);
      chk(ctl.vcode, 18'(vlim(63, 0)), "vcap");
      chk(ctl.icode, 18'h1, "icap");
      u_chs_host_model.wr(8'h06, 8'h7F);
      u_chs_host_model.keepalive;
      u_chs_host_model.wr(8'h02, 8'hFC);
      u_chs_host_model.rd(8'h02, q);
      chk(q[7:2], 18'(vlim(63, 0)), "lock");
      u_chs_host_model.keepalive;
      endt("ceiling");
      for (int c = 0; c < 4; c++) begin
         u_chs_host_model.wr(8'h01, {2'(c), 6'($urandom) & 6'h3B});
         cyc(2);
         chk(ctl.ilim, 18'(c), "lim code");
      end
      q = 8'($urandom % 8);
      u_chs_host_model.wr(8'h05, q);
      cyc(2);
      chk(ctl.hsel, 18'(q), "hsel");
      pins.holdup <= 1'b1;
      u_chs_host_model.rd(8'h05, q);
      chk(q[4], 18'h1, "holdup");
      endt("fields");
      cyc(200);
      u_chs_host_model.keepalive;
      cyc(1500);
      chk(ctl.ilim, 18'h3, "kept");
      wstat(700);
      cyc(4);
      chk(ctl.ilim, 18'h0, "wd lim");
      chk(ctl.vcode, 18'h2, "wd vcode");
      pins.host_mode <= 1'b1;
      cyc(6);
      chk(ctl.ilim, 18'h1, "unatt lim");
      wstat(3200);
      cyc(4);
      chk(ctl.chg, 18'h0, "unatt stop");
      u_chs_host_model.rd(8'h00, q);
      chk(q[2:0], 18'h6, "fault");
      chk(ctl.chg, 18'h0, "stays off");
      u_chs_host_model.wr(8'h01, 8'h00);
      cyc(40);
      chk(ctl.chg, 18'h1, "rearm");
      endt("timers");
      pins.foldback <= 1'b1;
      cyc(6);
      chk(ctl.fold, 18'h1, "fold");
      pins.tshut <= 1'b1;
      wstat(10);
      cyc(2600);
      chk(ctl.chg, 18'h0, "tshut");
      chk(ctl.ilim, 18'h0, "frozen");
      pins.tshut <= 1'b0;
      cyc(6);
      chk(ctl.chg, 18'h1, "cooled");
      pins.supply_ovp <= 1'b1;
      cyc(6);
      chk(ctl.chg, 18'h0, "ovp");
      pins.supply_ovp <= 1'b0;
      cyc(10);
      chk(ctl.chg, 18'h0, "reval");
      cyc(30);
      chk(ctl.chg, 18'h1, "restart");
      chk(u_chs_host_model.ack_ok, 18'h1, "acks");
      endt("thermal");
      final_report;
   end
endmodule
